// ---- shared/viu_pkg.sv ----
`default_nettype none
package viu_pkg;

  // Source bit positions in request and enable registers
  localparam int BIT_EXT    = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_TMRA   = 2;
  localparam int BIT_TMRB   = 3;
  localparam int BIT_PORT   = 4;
  localparam int BIT_BASE   = 5;
  localparam int NUM_SRC    = 6;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_REQ  = 14'h003C;
  localparam logic [13:0] IDX_ENA  = 14'h003E;
  localparam logic [13:0] IDX_CTRL = 14'h0040;
  localparam logic [13:0] IDX_STAT = 14'h0041;

  // Reset values
  localparam logic [7:0] REQ_RST  = 8'h00;
  localparam logic [7:0] ENA_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] P_RST    = 8'h24;

  // Status register fields
  localparam int P_I_BIT = 2;
  localparam int P_D_BIT = 3;
  localparam int P_B_BIT = 4;
  localparam int P_ONE_BIT = 5;

  // Control register fields
  localparam int CTRL_RISE_BIT = 0;

  // Vector low-byte addresses, high byte at +1
  localparam logic [15:0] VEC_BRK    = 16'h7FFE;
  localparam logic [15:0] VEC_RST    = 16'h7FFC;
  localparam logic [15:0] VEC_EXT    = 16'h7FF8;
  localparam logic [15:0] VEC_RELOAD = 16'h7FF6;
  localparam logic [15:0] VEC_TMRA   = 16'h7FF4;
  localparam logic [15:0] VEC_TMRB   = 16'h7FF2;
  localparam logic [15:0] VEC_PORT   = 16'h7FF0;
  localparam logic [15:0] VEC_BASE   = 16'h7FEE;

  localparam logic [7:0] STACK_PAGE = 8'h01;

  // Initialization length after reset release, in clock cycles
  localparam int RST_INIT_CYCLES = 6;

  typedef enum {
    ST_INIT, ST_IDLE, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_P, ST_FETCH_LO, ST_FETCH_HI, ST_LOAD
  } viu_state_e;

  // Memory request toward the CPU bus
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } viu_mem_s;

endpackage
`default_nettype wire

// ---- core/viu_prio_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
module viu_prio_arbiter
  import viu_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] pending,
  input  wire logic               brkReq,
  output logic                    anyReq,
  output logic [NUM_SRC-1:0]      grantHot,
  output logic [15:0]             vector,
  output logic                    isBrk
);

  // Vector table for the hardware sources
  function automatic logic [15:0] srcVector(input int idx);
    unique case (idx)
      BIT_EXT:    srcVector = VEC_EXT;
      BIT_RELOAD: srcVector = VEC_RELOAD;
      BIT_TMRA:   srcVector = VEC_TMRA;
      BIT_TMRB:   srcVector = VEC_TMRB;
      BIT_PORT:   srcVector = VEC_PORT;
      default:    srcVector = VEC_BASE;
    endcase
  endfunction

  // Lowest bit wins; break only when no hardware source waits
  always_comb begin
    grantHot = '0;
    vector   = VEC_BRK;
    isBrk    = 1'b0;
    anyReq   = 1'b0;
    for (int i = NUM_SRC-1; i >= 0; i--) begin
      if (pending[i]) begin
        grantHot = '0;
        grantHot[i] = 1'b1;
        vector   = srcVector(i);
        anyReq   = 1'b1;
      end
    end
    if (!anyReq && brkReq) begin
      isBrk  = 1'b1;
      anyReq = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- core/viu_core.sv ----
// Function
// [R1] Software break interrupts only with I clear; vector at 7FFE/7FFF.
// [R2] Reset input must stay low at least two clocks to stop activity.
// [R3] After reset release, six-cycle initialization precedes the restart fetch.
// [R4] Initialization end sets I, clears D, loads PC from 7FFC/7FFD.
// [R5] External edge sets its flag; taken when enabled and unmasked, vector 7FF8.
// [R6] Reload event sets its flag; taken when enabled and unmasked, vector 7FF6.
// [R7] First timer overflow sets its flag; vector 7FF4 when enabled.
// [R8] Second timer overflow sets its flag; vector 7FF2 when enabled.
// [R9] Port transition sets its flag; vector 7FF0 when enabled.
// [R10] Base timer overflow sets its flag; vector 7FEE when enabled and unmasked.
// [R11] Entry pushes PC then status, sets I before vector fetch.
// [R12] Fixed priority: reset, ext, reload, timer A, timer B, port, base, break.
// [R13] Writing zero to a request bit clears that flag only.
// [R14] Entering service clears the served source's request flag.
// [R15] Request bits: base 5, port 4, timer B 3, timer A 2, reload 1, ext 0.
// [R16] Enable register uses same bit positions, one enables.
// [R17] Status bit 2 set blocks all maskable hardware sources.
// [R18] Stack pushes address page 100H-1FFH through the 8-bit pointer.
// [R19] Disabled or masked flags stay pending until served or cleared.
// [R20] Request and enable registers reset to zero.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module viu_core
  import viu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalEdgeInput,
  input  wire logic        reloadEvent,
  input  wire logic        timerAOverflow,
  input  wire logic        timerBOverflow,
  input  wire logic        portChangeEvent,
  input  wire logic        baseTickOverflow,
  input  wire logic        brkReq,
  input  wire logic        cpuBoundary,
  input  wire logic [15:0] cpuPc,
  input  wire logic [7:0]  cpuSp,
  input  wire logic        cpuStatusWe,
  input  wire logic [7:0]  cpuStatusIn,
  output viu_mem_s         memReq,
  input  wire logic [7:0]  memRdData,
  output logic             seqBusy,
  output logic             pcLoad,
  output logic [15:0]      newPc,
  output logic             spLoad,
  output logic [7:0]       newSp,
  output logic [7:0]       statusP
);

  localparam logic [2:0] INIT_LAST = 3'(RST_INIT_CYCLES - 1);

  function automatic logic [15:0] byteAddr(input logic [13:0] idx);
    byteAddr = {idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register and state declarations
  viu_state_e        st_r, st_nxt;
  logic [2:0]        initCnt_r, initCnt_nxt;
  logic [NUM_SRC-1:0] req_r, req_nxt;
  logic [NUM_SRC-1:0] ena_r, ena_nxt;
  logic [7:0]        ctrl_r, ctrl_nxt;
  logic [7:0]        p_r, p_nxt;
  logic              extPrev_r;
  logic [15:0]       vec_r, vec_nxt;
  logic              brkSel_r, brkSel_nxt;
  logic [15:0]       pcSave_r, pcSave_nxt;
  logic [7:0]        sp_r, sp_nxt;
  logic [7:0]        pcLo_r, pcLo_nxt;
  viu_mem_s          mem_r, mem_nxt;
  logic              pcLoad_r, pcLoad_nxt;
  logic [15:0]       newPc_r, newPc_nxt;
  logic              spLoad_r, spLoad_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pslverr_r, pslverr_nxt;

  logic [NUM_SRC-1:0] eventVec, pending, grantHot, swKeep, hwClr;
  logic              extEdge, anyReq, isBrk, accept, brkOk, wrAccess, setup;
  logic [15:0]       arbVector;
  logic [7:0]        pushP;

  ////////////////////////////////////////////////////////////////////////////
  // Event capture and masking
  assign extEdge = ctrl_r[CTRL_RISE_BIT] ? (externalEdgeInput & ~extPrev_r)
                                         : (~externalEdgeInput & extPrev_r);
  assign eventVec = {baseTickOverflow, portChangeEvent, timerBOverflow,
                     timerAOverflow, reloadEvent, extEdge}; // R15
  assign pending  = req_r & ena_r & {NUM_SRC{~p_r[P_I_BIT]}}; // R17 R16 R19
  assign brkOk    = brkReq & ~p_r[P_I_BIT]; // R1

  viu_prio_arbiter u_arb (
    .pending  (pending),
    .brkReq   (brkOk),
    .anyReq   (anyReq),
    .grantHot (grantHot),
    .vector   (arbVector),
    .isBrk    (isBrk)
  );

  // Entry only at an instruction boundary while idle
  assign accept = (st_r == ST_IDLE) && cpuBoundary && anyReq; // R12
  assign hwClr  = accept ? grantHot : '0; // R14

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, data prepared during setup
  assign setup    = psel & ~penable;
  assign wrAccess = psel & penable & pwrite;
  assign swKeep   = (wrAccess && paddr == byteAddr(IDX_REQ)) ? pwdata[NUM_SRC-1:0] : '1; // R13

  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      pslverr_nxt = 1'b0;
      unique case (paddr)
        byteAddr(IDX_REQ):  prdata_nxt = {26'h0, req_r};
        byteAddr(IDX_ENA):  prdata_nxt = {26'h0, ena_r};
        byteAddr(IDX_CTRL): prdata_nxt = {24'h0, ctrl_r};
        byteAddr(IDX_STAT): prdata_nxt = {23'h0, seqBusy, p_r};
        default: begin
          prdata_nxt  = 32'h0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  // Flags: an event in the clearing cycle still sets its flag
  always_comb begin
    req_nxt  = (req_r & swKeep & ~hwClr) | eventVec; // R5 R6 R7 R8 R9 R10 R13 R14 R19
    ena_nxt  = ena_r;
    ctrl_nxt = ctrl_r;
    if (wrAccess && paddr == byteAddr(IDX_ENA)) begin
      ena_nxt = pwdata[NUM_SRC-1:0]; // R16
    end
    if (wrAccess && paddr == byteAddr(IDX_CTRL)) begin
      ctrl_nxt = pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry sequencer and its memory requests
  assign pushP = {p_r[7:6], 1'b1, brkSel_r, p_r[3:0]};

  always_comb begin
    st_nxt      = st_r;
    initCnt_nxt = initCnt_r;
    p_nxt       = p_r;
    vec_nxt     = vec_r;
    brkSel_nxt  = brkSel_r;
    pcSave_nxt  = pcSave_r;
    sp_nxt      = sp_r;
    pcLo_nxt    = pcLo_r;
    mem_nxt     = '0;
    pcLoad_nxt  = 1'b0;
    newPc_nxt   = newPc_r;
    spLoad_nxt  = 1'b0;
    if (cpuStatusWe) begin
      p_nxt = cpuStatusIn | (8'h01 << P_ONE_BIT);
    end
    unique case (st_r)
      ST_INIT: begin
        initCnt_nxt = initCnt_r + 3'h1;
        if (initCnt_r == INIT_LAST) begin // R3
          st_nxt  = ST_FETCH_LO;
          vec_nxt = VEC_RST;
          p_nxt   = (p_r | (8'h01 << P_I_BIT)) & ~(8'h01 << P_D_BIT); // R4
          mem_nxt = '{addr: VEC_RST, wdata: 8'h00, we: 1'b0, re: 1'b1};
        end
      end
      ST_IDLE: begin
        if (accept) begin
          st_nxt     = ST_PUSH_HI;
          vec_nxt    = arbVector;
          brkSel_nxt = isBrk;
          pcSave_nxt = cpuPc;
          sp_nxt     = cpuSp - 8'h01;
          mem_nxt    = '{addr: {STACK_PAGE, cpuSp}, wdata: cpuPc[15:8], we: 1'b1, re: 1'b0}; // R11 R18
        end
      end
      ST_PUSH_HI: begin
        st_nxt  = ST_PUSH_LO;
        sp_nxt  = sp_r - 8'h01;
        mem_nxt = '{addr: {STACK_PAGE, sp_r}, wdata: pcSave_r[7:0], we: 1'b1, re: 1'b0}; // R18
      end
      ST_PUSH_LO: begin
        st_nxt  = ST_PUSH_P;
        sp_nxt  = sp_r - 8'h01;
        mem_nxt = '{addr: {STACK_PAGE, sp_r}, wdata: pushP, we: 1'b1, re: 1'b0}; // R11
      end
      ST_PUSH_P: begin
        st_nxt  = ST_FETCH_LO;
        p_nxt   = p_r | (8'h01 << P_I_BIT); // R11
        mem_nxt = '{addr: vec_r, wdata: 8'h00, we: 1'b0, re: 1'b1};
      end
      ST_FETCH_LO: begin
        st_nxt  = ST_FETCH_HI;
        mem_nxt = '{addr: vec_r + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
      end
      ST_FETCH_HI: begin
        st_nxt   = ST_LOAD;
        pcLo_nxt = memRdData;
      end
      ST_LOAD: begin
        st_nxt     = ST_IDLE;
        pcLoad_nxt = 1'b1; // R1 R4
        newPc_nxt  = {memRdData, pcLo_r};
        spLoad_nxt = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers; reset holds the sequencer in initialization
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= ST_INIT;
      initCnt_r <= 3'h0;
      req_r     <= REQ_RST[NUM_SRC-1:0]; // R20
      ena_r     <= ENA_RST[NUM_SRC-1:0]; // R20
      ctrl_r    <= CTRL_RST;
      p_r       <= P_RST;
      extPrev_r <= 1'b0;
      vec_r     <= 16'h0000;
      brkSel_r  <= 1'b0;
      pcSave_r  <= 16'h0000;
      sp_r      <= 8'h00;
      pcLo_r    <= 8'h00;
      mem_r     <= '0;
      pcLoad_r  <= 1'b0;
      newPc_r   <= 16'h0000;
      spLoad_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      initCnt_r <= initCnt_nxt;
      req_r     <= req_nxt;
      ena_r     <= ena_nxt;
      ctrl_r    <= ctrl_nxt;
      p_r       <= p_nxt;
      extPrev_r <= externalEdgeInput;
      vec_r     <= vec_nxt;
      brkSel_r  <= brkSel_nxt;
      pcSave_r  <= pcSave_nxt;
      sp_r      <= sp_nxt;
      pcLo_r    <= pcLo_nxt;
      mem_r     <= mem_nxt;
      pcLoad_r  <= pcLoad_nxt;
      newPc_r   <= newPc_nxt;
      spLoad_r  <= spLoad_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs
  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = pslverr_r & psel & penable;
  assign memReq  = mem_r;
  assign seqBusy = (st_r != ST_IDLE);
  assign pcLoad  = pcLoad_r;
  assign newPc   = newPc_r;
  assign spLoad  = spLoad_r;
  assign newSp   = sp_r;
  assign statusP = p_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_INIT_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    (st_r == ST_FETCH_LO && $past(st_r) == ST_INIT) |-> $past(initCnt_r) == INIT_LAST)
    else $error("initialization length wrong");

  AST_RST_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (st_r == ST_FETCH_LO && $past(st_r) == ST_INIT) |->
      p_r[P_I_BIT] && !p_r[P_D_BIT] && mem_r.re && mem_r.addr == VEC_RST)
    else $error("restart entry flags or vector wrong");

  AST_EVT_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    (|eventVec) |=> ((req_r & $past(eventVec)) == $past(eventVec)))
    else $error("event did not set its flag");

  AST_SW_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    (swKeep != '1 && eventVec == '0 && !accept) |=> req_r == ($past(req_r) & $past(swKeep)))
    else $error("software clear touched other flags");

  AST_AUTO_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    (accept && !isBrk) |=> (req_r & $past(grantHot)) == ($past(eventVec) & $past(grantHot)))
    else $error("served flag not cleared");

  AST_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
    (st_r == ST_IDLE && p_r[P_I_BIT]) |=> (st_r == ST_IDLE))
    else $error("entry taken while masked");

  AST_PRIO: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    (accept && !isBrk) |-> ((req_r & ena_r & (grantHot - 6'h01)) == 6'h00))
    else $error("lower priority source won");

  AST_PUSH_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    accept |=> (mem_r.we && mem_r.addr[15:8] == STACK_PAGE && mem_r.wdata == $past(cpuPc[15:8]))
      ##1 (mem_r.we && mem_r.addr[15:8] == STACK_PAGE)
      ##1 (mem_r.we && mem_r.wdata[P_B_BIT] == brkSel_r)
      ##1 (p_r[P_I_BIT] && mem_r.re && mem_r.addr == vec_r))
    else $error("entry push order wrong");

  AST_PC_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (st_r == ST_FETCH_HI) |=> ##1 (pcLoad && newPc[7:0] == $past(memRdData, 2)))
    else $error("vector not loaded");

endmodule
`default_nettype wire

// ---- bench/viu_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: vector memory and stack page behind the entry sequencer
module viu_cpu_model
  import viu_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire viu_mem_s memReq,
  output logic [7:0]    memRdData
);
  logic [7:0] stackMem [256];

  initial memRdData = 8'h00;

  // Read answers next cycle; idle cycles flip the bus so stale data never looks valid
  always @(posedge clk_sys) begin
    memRdData <= memReq.re ? memReq.addr[7:0] + 8'h11 : ~memRdData;
    if (memReq.we && memReq.addr[15:8] == 8'h01) begin
      stackMem[memReq.addr[7:0]] <= memReq.wdata;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import viu_pkg::*;
  localparam logic [15:0] A_REQ = {IDX_REQ, 2'b00};
  localparam logic [15:0] A_ENA = {IDX_ENA, 2'b00};
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000, cpuPc = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rdQ;
  logic        pready, pslverr, rdE, seqBusy, pcLoad, spLoad;
  logic        extIn = 1'b1, brkReq = 1'b0, cpuBoundary = 1'b0, cpuStatusWe = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [7:0]  cpuSp = 8'h00, cpuStatusIn = 8'h00, memRdData, newSp, statusP;
  logic [15:0] newPc, vec;
  viu_mem_s    memReq;
  int          mismatches = 0, checks = 0, cyc = 0, n;

  always #2.5 clk_sys = ~clk_sys;

  viu_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .externalEdgeInput(extIn), .reloadEvent(ev[1]), .timerAOverflow(ev[2]), .timerBOverflow(ev[3]),
    .portChangeEvent(ev[4]), .baseTickOverflow(ev[5]), .brkReq(brkReq), .cpuBoundary(cpuBoundary),
    .cpuPc(cpuPc), .cpuSp(cpuSp), .cpuStatusWe(cpuStatusWe), .cpuStatusIn(cpuStatusIn),
    .memReq(memReq), .memRdData(memRdData), .seqBusy(seqBusy), .pcLoad(pcLoad), .newPc(newPc),
    .spLoad(spLoad), .newSp(newSp), .statusP(statusP));

  viu_cpu_model uPart (.clk_sys(clk_sys), .memReq(memReq), .memRdData(memRdData));

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No cycle count assumed; a stuck slave is ended by the hang guard
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdQ = prdata; rdE = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdQ);
    chk("pslverr", {31'h0, ee}, {31'h0, rdE});
  endtask

  // Source k: 0 toggles the edge input, others pulse one cycle
  task automatic fire(input int k);
    @(posedge clk_sys);
    if (k == 0) extIn <= ~extIn;
    else ev[k] <= 1'b1;
    @(posedge clk_sys);
    ev <= 6'h00;
  endtask

  task automatic setStatus(input logic [7:0] v);
    @(posedge clk_sys);
    cpuStatusWe <= 1'b1; cpuStatusIn <= v;
    @(posedge clk_sys);
    cpuStatusWe <= 1'b0;
  endtask

  task automatic waitLoad(input int lim);
    n = 0;
    do begin @(negedge clk_sys); n++; end while (pcLoad !== 1'b1 && n < lim);
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    waitLoad(30);
    // Half cycle before the first edge, then nine edges to the load
    chk("init cycles", 10, n);
    chk("restart pc", 16'h0E0D, newPc);
    chk("status d i", 2'b01, statusP[3:2]);
    rd("req reset", A_REQ, 32'h0, 1'b0);
    rd("ena reset", A_ENA, 32'h0, 1'b0);
    rd("status reg", {IDX_STAT, 2'b00}, 32'h0000_0024, 1'b0);
    rd("unmapped", 16'h0200, 32'h0, 1'b1);
    for (int k = 0; k < NUM_SRC; k++) fire(k);
    rd("req all", A_REQ, 32'h3F, 1'b0);
    apb(1'b1, A_REQ, 32'h3B);
    rd("req clear one", A_REQ, 32'h3B, 1'b0);
    fire(2);
    // Rising polarity for the edge input
    apb(1'b1, 16'h0100, 32'h1);
    rd("ctrl", 16'h0100, 32'h1, 1'b0);
    apb(1'b1, A_REQ, 32'h3E);
    fire(0);
    rd("req refill", A_REQ, 32'h3F, 1'b0);
    apb(1'b1, A_ENA, 32'h3F);
    rd("ena", A_ENA, 32'h3F, 1'b0);
    @(posedge clk_sys);
    cpuBoundary <= 1'b1; brkReq <= 1'b1;
    waitLoad(20);
    chk("masked entry", 0, pcLoad);
    // One entry per source in priority order, break last
    for (int k = 0; k < 7; k++) begin
      vec = (k == 6) ? 16'h7FFE : 16'h7FF8 - 16'(2 * k);
      cpuPc <= 16'h4000 + 16'(k);
      setStatus(8'h00);
      waitLoad(40);
      chk("vector", {vec[7:0] + 8'h12, vec[7:0] + 8'h11}, newPc);
      chk("i after entry", 1, statusP[P_I_BIT]);
      chk("new sp", 8'hFD, newSp);
      chk("sp load", 1, spLoad);
      chk("push pch", 8'h40, uPart.stackMem[8'h00]);
      chk("push pcl", k, uPart.stackMem[8'hFF]);
      chk("push p", (k == 6) ? 8'h30 : 8'h20, uPart.stackMem[8'hFE]);
      rd("req served", A_REQ, (32'h3F << (k + 1)) & 32'h3F, 1'b0);
    end
    waitLoad(20);
    chk("break masked", 0, pcLoad);
    brkReq <= 1'b0;
    // Mid-run reset with a flag pending: flags and enables must come back clear
    fire(3);
    rd("req before reset", A_REQ, 32'h08, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    waitLoad(30);
    chk("reinit cycles", 10, n);
    rd("req after reset", A_REQ, 32'h0, 1'b0);
    rd("ena after reset", A_ENA, 32'h0, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
